/* inc/asrp_regs.vh */
`ifndef ASRP_REGS_VH
`define ASRP_REGS_VH
// ==========================================================
// register map (byte addresses)
`define ASRP_OFF_CTRL 12'h000
`define ASRP_OFF_STATUS 12'h004
`define ASRP_OFF_MASK 12'h008
`define ASRP_OFF_RESULT 12'h00C
`define ASRP_OFF_STATE 12'h010
// ==========================================================
// control fields
`define ASRP_CTRL_MODE_LO 0
`define ASRP_CTRL_MODE_HI 1
`define ASRP_CTRL_CLK_SRC 2
`define ASRP_CTRL_CLK_INV 3
`define ASRP_CTRL_FRM_POL 4
`define ASRP_CTRL_FMT 5
`define ASRP_CTRL_W 6
`define ASRP_CTRL_RESET 6'h00
`define ASRP_MODE_SERIAL 2'h3
// ==========================================================
// status / mask fields
`define ASRP_ST_READY 0
`define ASRP_ST_LATE 1
`define ASRP_ST_DONE 2
`define ASRP_ST_W 3
`define ASRP_ST_RESET 3'h0
// ==========================================================
// serial geometry and timing
`define ASRP_RES_W 18
`define ASRP_BITS 5'h12
`define ASRP_LAST_BIT 5'h11
`define ASRP_SCLK_PHASES 4
`define ASRP_PH_W 2
`define ASRP_PH_SHIFT 2'h3
`endif

/* rtl/asrp_sync.v */
`timescale 1ns/100ps
// ==========================================================
// two flip-flop level synchroniser, one stage pair per bit
module asrp_sync #(
  parameter WIDTH = 2
) (
  input wire mclk_in, // block clock
  input wire rst_n_in, // async reset, active low
  input wire [WIDTH-1:0] async_in, // levels from outside
  output wire [WIDTH-1:0] sync_out // levels in mclk domain
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // asrp_sync

/* rtl/asrp_port.v */
`timescale 1ns/100ps
`include "asrp_regs.vh"
// How it works
// - parallel bits on shared pins unless mode 3
// - external clock: chain pin is serial input
// - chain level appears after 18 shift periods
// - internal, timing high: shift during conversion
// - internal, timing low: shift after conversion
// - shift result out msb first
// - format select picks binary or twos complement
// - internal clock: bit valid both edges
// - external, no invert: update on rising
// - external, invert: update on falling
// - clock pin output internal, input external
// - frame marker delimits internal-clock data
// - polarity low: marker high while valid
// - polarity high: marker low while valid
// - clock source low makes clock, high follows host
// - invert shift clock in both modes
// - unfinished external read on new result: flag
// - busy from start until result latched
module asrp_port (
  input wire mclk_in, // 10 MHz block clock
  input wire rst_n_in, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error, unmapped address
  output wire irq_out, // level interrupt
  input wire conv_start_in, // converter starts, pulse
  input wire conv_done_in, // converter result valid, pulse
  input wire [17:0] conv_result_in, // straight binary result
  output wire busy_out, // conversion in progress
  output wire late_read_flag_out, // late read pulse
  input wire read_timing_or_chain_input_in, // pin, async
  output wire parallel_bit_ten_out, // bit 10 or serial data
  input wire parallel_bit_eleven_in, // clock pin level
  output wire parallel_bit_eleven_out, // bit 11 or shift clock
  output wire parallel_bit_eleven_oe_n_out, // low drives pin
  output wire parallel_bit_twelve_out // bit 12 or frame marker
);
  // ==========================================================
  // states
  localparam ST_IDLE = 3'b001;
  localparam ST_ARMED = 3'b010;
  localparam ST_SHIFT = 3'b100;

  reg [`ASRP_CTRL_W-1:0] ctrl_q;
  reg [`ASRP_ST_W-1:0] status_q;
  reg [`ASRP_ST_W-1:0] mask_q;
  reg [`ASRP_RES_W-1:0] result_q;
  reg have_result_q;
  reg busy_q;
  reg [2:0] state_q;
  reg [`ASRP_RES_W-1:0] shreg_q;
  reg [4:0] bitcnt_q;
  reg [`ASRP_PH_W-1:0] phase_q;
  reg ext_clk_d_q;
  reg chain_bit_q;
  reg late_q;
  reg [31:0] rdata_q;
  reg slverr_q;
  wire [1:0] pins_sync;
  wire ext_clk_s;
  wire rt_chain_s;
  wire serial_mode;
  wire clk_ext;
  wire clk_inv;
  wire frm_pol;
  wire fmt_bin;
  wire ext_rise;
  wire ext_fall;
  wire upd_edge;
  wire smp_edge;
  wire [`ASRP_RES_W-1:0] coded;
  wire int_start;
  wire int_shift;
  wire int_last;
  wire read_done;
  wire late_ev;
  wire setup_ph;
  wire wr_en;
  wire hit;
  wire sclk_int;

  // ==========================================================
  // configuration, held stable by host during a read
  assign serial_mode = (ctrl_q[`ASRP_CTRL_MODE_HI:`ASRP_CTRL_MODE_LO]
                        == `ASRP_MODE_SERIAL);
  assign clk_ext = ctrl_q[`ASRP_CTRL_CLK_SRC];
  assign clk_inv = ctrl_q[`ASRP_CTRL_CLK_INV];
  assign frm_pol = ctrl_q[`ASRP_CTRL_FRM_POL];
  assign fmt_bin = ctrl_q[`ASRP_CTRL_FMT];

  // ==========================================================
  // pin synchronisers: clock pin and timing/chain pin
  asrp_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in({parallel_bit_eleven_in, read_timing_or_chain_input_in}),
    .sync_out(pins_sync)
  );
  assign ext_clk_s = pins_sync[1];
  assign rt_chain_s = pins_sync[0];

  // edges of the host clock, found on the synchronised copy
  assign ext_rise = ext_clk_s & ~ext_clk_d_q;
  assign ext_fall = ~ext_clk_s & ext_clk_d_q;
  assign upd_edge = clk_inv ? ext_fall : ext_rise;
  assign smp_edge = clk_inv ? ext_rise : ext_fall;

  // twos complement flips the msb of the offset-binary code
  assign coded = fmt_bin ? conv_result_in :
                 {~conv_result_in[`ASRP_RES_W-1],
                  conv_result_in[`ASRP_RES_W-2:0]};

  // ==========================================================
  // internal-clock read control
  // timing high reuses the previous result while converting
  assign int_start = serial_mode & ~clk_ext & (state_q == ST_IDLE) &
                     ((rt_chain_s & conv_start_in & have_result_q) |
                      (~rt_chain_s & conv_done_in));
  assign int_shift = (state_q == ST_SHIFT) & ~clk_ext &
                     (phase_q == `ASRP_PH_SHIFT);
  assign int_last = int_shift & (bitcnt_q == `ASRP_LAST_BIT);
  // clock high in mid phases; data moves only at phase 0,
  // so each bit sits across both edges
  assign sclk_int = (state_q == ST_SHIFT) & ~clk_ext &
                    (phase_q == 2'h1 || phase_q == 2'h2);

  // ==========================================================
  // external-clock read control
  assign late_ev = serial_mode & clk_ext & conv_done_in &
                   (state_q == ST_SHIFT);
  assign read_done = int_last | (serial_mode & clk_ext &
                     upd_edge & (state_q == ST_SHIFT) &
                     (bitcnt_q == `ASRP_LAST_BIT));

  // ==========================================================
  // converter result and busy
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_q <= {`ASRP_RES_W{1'b0}};
      have_result_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (conv_done_in) begin
        result_q <= coded;
        have_result_q <= 1'b1;
        busy_q <= 1'b0;
      end else if (conv_start_in) begin
        busy_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // shift engine and read state
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      shreg_q <= {`ASRP_RES_W{1'b0}};
      bitcnt_q <= 5'h00;
      phase_q <= {`ASRP_PH_W{1'b0}};
      ext_clk_d_q <= 1'b0;
      chain_bit_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      ext_clk_d_q <= ext_clk_s;
      late_q <= late_ev;
      // chain level caught on the host sampling edge
      if (smp_edge) begin
        chain_bit_q <= rt_chain_s;
      end
      if (!serial_mode) begin
        state_q <= ST_IDLE;
      end else if (clk_ext) begin
        if (conv_done_in) begin
          // new result replaces any unfinished read
          shreg_q <= coded;
          bitcnt_q <= 5'h00;
          state_q <= ST_ARMED;
        end else if (upd_edge) begin
          // shifting never stops, so later chain bits follow
          shreg_q <= {shreg_q[`ASRP_RES_W-2:0], chain_bit_q};
          case (state_q)
            ST_ARMED: begin
              state_q <= ST_SHIFT;
              bitcnt_q <= 5'h01;
            end
            ST_SHIFT: begin
              if (bitcnt_q == `ASRP_LAST_BIT) begin
                state_q <= ST_IDLE;
              end
              bitcnt_q <= bitcnt_q + 5'h01;
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (int_start) begin
              shreg_q <= conv_done_in ? coded : result_q;
              bitcnt_q <= 5'h00;
              phase_q <= {`ASRP_PH_W{1'b0}};
              state_q <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            phase_q <= phase_q + 2'h1;
            if (int_last) begin
              state_q <= ST_IDLE;
            end else if (int_shift) begin
              shreg_q <= {shreg_q[`ASRP_RES_W-2:0], 1'b0};
              bitcnt_q <= bitcnt_q + 5'h01;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // apb slave: zero wait, read data captured in setup phase
  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pwrite & ~slverr_q;
  assign hit = (paddr == `ASRP_OFF_CTRL) ||
               (paddr == `ASRP_OFF_STATUS) ||
               (paddr == `ASRP_OFF_MASK) ||
               (paddr == `ASRP_OFF_RESULT) ||
               (paddr == `ASRP_OFF_STATE);

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else if (setup_ph) begin
      slverr_q <= ~hit;
      if (paddr == `ASRP_OFF_CTRL) begin
        rdata_q <= {26'h0000000, ctrl_q};
      end else if (paddr == `ASRP_OFF_STATUS) begin
        rdata_q <= {29'h00000000, status_q};
      end else if (paddr == `ASRP_OFF_MASK) begin
        rdata_q <= {29'h00000000, mask_q};
      end else if (paddr == `ASRP_OFF_RESULT) begin
        rdata_q <= {14'h0000, result_q};
      end else if (paddr == `ASRP_OFF_STATE) begin
        rdata_q <= {24'h000000, bitcnt_q, state_q};
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // control, mask and sticky status; a set beats a clear
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= `ASRP_CTRL_RESET;
      mask_q <= `ASRP_ST_RESET;
      status_q <= `ASRP_ST_RESET;
    end else begin
      if (wr_en && paddr == `ASRP_OFF_CTRL) begin
        ctrl_q <= pwdata[`ASRP_CTRL_W-1:0];
      end
      if (wr_en && paddr == `ASRP_OFF_MASK) begin
        mask_q <= pwdata[`ASRP_ST_W-1:0];
      end
      status_q <= (status_q &
                   ~((wr_en && paddr == `ASRP_OFF_STATUS) ?
                     pwdata[`ASRP_ST_W-1:0] : `ASRP_ST_RESET)) |
                  {read_done, late_ev, conv_done_in};
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & slverr_q;
  assign irq_out = |(status_q & mask_q);

  // ==========================================================
  // pin multiplexing between parallel and serial use
  assign busy_out = busy_q;
  assign late_read_flag_out = late_q;
  assign parallel_bit_ten_out = serial_mode ?
                                shreg_q[`ASRP_RES_W-1] :
                                result_q[10];
  assign parallel_bit_eleven_out = serial_mode ?
                                   (sclk_int ^ clk_inv) :
                                   result_q[11];
  assign parallel_bit_eleven_oe_n_out = serial_mode & clk_ext;
  // marker active only for internal-clock frames
  assign parallel_bit_twelve_out = serial_mode ?
    (((state_q == ST_SHIFT) & ~clk_ext) ^ frm_pol) :
    result_q[12];
endmodule // asrp_port

/* tb/asrp_port_props.sv */
`timescale 1ns/100ps
// ======
// port checker
module asrp_port_props (
  input wire mclk_in, // block clock
  input wire rst_n_in, // async reset
  input wire psel, // apb select
  input wire penable, // apb access
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb data
  input wire conv_start_in, // start pulse
  input wire conv_done_in, // done pulse
  input wire busy_out, // busy
  input wire late_read_flag_out, // late pulse
  input wire parallel_bit_ten_out, // data pin
  input wire parallel_bit_eleven_in, // clock pin in
  input wire parallel_bit_eleven_out, // clock pin out
  input wire parallel_bit_eleven_oe_n_out, // clock enable
  input wire parallel_bit_twelve_out // marker pin
);
  reg [5:0] ctl_q;
  reg [2:0] age_q;
  reg [6:0] frm_q;
  reg [2:0] edg_q;
  reg pin_q;
  wire wr = psel && penable && pwrite && paddr == 12'h000;
  wire ext = ctl_q[1:0] == 2'h3 && ctl_q[2];
  wire mk = ctl_q[1:0] == 2'h3 && !ctl_q[2] &&
    parallel_bit_twelve_out != ctl_q[4];
  // shadow config; the raw pin is async, so edges are approximate
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_q <= 6'h00;
      age_q <= 3'h0;
      frm_q <= 7'h00;
      edg_q <= 3'h7;
      pin_q <= 1'b0;
    end else begin
      ctl_q <= wr ? pwdata[5:0] : ctl_q;
      age_q <= wr ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
      frm_q <= (mk && !wr) ? frm_q + 7'h01 : 7'h00;
      pin_q <= parallel_bit_eleven_in;
      if (parallel_bit_eleven_in != pin_q &&
          parallel_bit_eleven_in != ctl_q[3])
        edg_q <= 3'h0;
      else if (edg_q != 3'h7)
        edg_q <= edg_q + 3'h1;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_frame_end;
    mk ##1 !mk && age_q > 3'h1;
  endsequence
  pin_dir_a: assert property (
    age_q > 3'h1 |-> parallel_bit_eleven_oe_n_out == ext)
    else $error("clock pin direction");
  busy_set_a: assert property (
    conv_start_in && !conv_done_in |=> busy_out)
    else $error("busy not raised");
  busy_clr_a: assert property (
    conv_done_in && !conv_start_in |-> ##[1:2] !busy_out)
    else $error("busy not cleared");
  late_src_a: assert property (
    late_read_flag_out |-> ext && $past(conv_done_in))
    else $error("late flag without cause");
  late_one_a: assert property (
    late_read_flag_out |=> !late_read_flag_out)
    else $error("late flag too long");
  ext_mark_a: assert property (
    ext && age_q > 3'h1 |-> parallel_bit_twelve_out == ctl_q[4])
    else $error("marker active in ext mode");
  frame_len_a: assert property (
    s_frame_end |-> frm_q == 7'd72)
    else $error("frame length");
  int_edge_a: assert property (
    mk && $past(mk) && $changed(parallel_bit_ten_out) |->
    parallel_bit_eleven_out == ctl_q[3] &&
    $past(parallel_bit_eleven_out) == ctl_q[3])
    else $error("data moved near clock edge");
  ext_upd_a: assert property (
    ext && age_q > 3'h2 && $changed(parallel_bit_ten_out) &&
    !$past(conv_done_in) && !$past(conv_done_in, 2) |->
    edg_q inside {[3'h1:3'h5]})
    else $error("data moved off update edge");
endmodule // asrp_port_props
bind asrp_port asrp_port_props chk_u (.mclk_in, .rst_n_in, .psel,
  .penable, .pwrite, .paddr, .pwdata, .conv_start_in, .conv_done_in,
  .busy_out, .late_read_flag_out, .parallel_bit_ten_out,
  .parallel_bit_eleven_in, .parallel_bit_eleven_out,
  .parallel_bit_eleven_oe_n_out, .parallel_bit_twelve_out);

/* tb/asrp_host.sv */
`timescale 1ns/100ps
// ======
// host model: makes the shift clock only within a read
module asrp_host (
  output logic sclk_out, // link clock
  output logic [35:0] word_out, // sampled bits
  input wire logic sdata_in // serial data
);
  initial sclk_out = 1'b0;
  initial word_out = 36'h0;
  // park at idle level, which is the invert setting
  task automatic park(input logic iv);
    sclk_out = iv;
  endtask
  // first bit is taken before any edge, then one per sample edge
  task automatic read(input int n, input logic iv);
    #250;
    word_out = {word_out[34:0], sdata_in};
    repeat (n) begin
      #400 sclk_out = ~iv;
      #400 sclk_out = iv;
      word_out = {word_out[34:0], sdata_in};
    end
  endtask
endmodule // asrp_host

/* tb/adc_serial_result_port_tb_top.sv */
`timescale 1ns/100ps
// ======
// bench top
module adc_serial_result_port_tb_top;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic conv_start_in = 1'b0;
  logic conv_done_in = 1'b0;
  logic [17:0] conv_result_in = 18'h0;
  logic rt_in = 1'b0;
  logic [31:0] q;
  logic e_q;
  wire [31:0] prdata;
  wire pready, pslverr, irq_out, busy_out, late_read_flag_out;
  wire ten, sclk, clk_o, oe_n, twelve;
  wire [35:0] word;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // the clock pin carries whoever is enabled
  wire pin = oe_n ? sclk : clk_o;
  asrp_port dut_u (.mclk_in, .rst_n_in, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_out,
    .conv_start_in, .conv_done_in, .conv_result_in, .busy_out,
    .late_read_flag_out, .read_timing_or_chain_input_in(rt_in),
    .parallel_bit_ten_out(ten), .parallel_bit_eleven_in(pin),
    .parallel_bit_eleven_out(clk_o),
    .parallel_bit_eleven_oe_n_out(oe_n),
    .parallel_bit_twelve_out(twelve));
  asrp_host host_u (.sclk_out(sclk), .word_out(word), .sdata_in(ten));
  always #50 mclk_in = ~mclk_in;
  // hang guard
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // apb master, holds the request until pready
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    @(posedge mclk_in);
    // only the hang guard ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge mclk_in);
    end
    q = prdata;
    e_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one-cycle converter pulse, start or done
  task automatic pulse(input logic s, input logic [17:0] r);
    @(posedge mclk_in);
    conv_result_in <= r;
    conv_start_in <= s;
    conv_done_in <= !s;
    @(posedge mclk_in);
    conv_start_in <= 1'b0;
    conv_done_in <= 1'b0;
  endtask
  // internal frame: bit every 4 cycles once the marker shows
  task automatic grab(input logic p, output logic [17:0] w);
    int n;
    n = 0;
    w = 18'h0;
    while (twelve === p && n < 200) begin
      n++;
      @(posedge mclk_in);
    end
    chk(36'(twelve), 36'(!p));
    repeat (18) begin
      w = {w[16:0], ten};
      repeat (4) @(posedge mclk_in);
    end
    chk(36'(twelve), 36'(p));
  endtask
  task automatic irq_is(input logic e);
    repeat (4) if (irq_out !== e) @(posedge mclk_in);
    chk(36'(irq_out), 36'(e));
  endtask
  task automatic regs_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(36'(q), 36'h0);
    end
    apb(1'b0, 12'h010, 32'h0);
    chk(36'(q), 36'h1);
    apb(1'b1, 12'h020, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(36'({e_q, q}), 36'h100000000);
  endtask
  task automatic par_pins();
    for (int i = 0; i < 2; i++) begin
      pulse(1'b0, i ? 18'h00800 : 18'h01400);
      repeat (2) @(posedge mclk_in);
      chk(36'({oe_n, twelve, clk_o, ten}), i ? 36'h2 : 36'h5);
    end
  endtask
  task automatic int_read(input logic p, input logic v, input logic f,
      input logic [17:0] r);
    logic [17:0] w;
    rt_in <= 1'b0;
    apb(1'b1, 12'h000, {26'h0, f, p, v, 1'b0, 2'h3});
    pulse(1'b1, 18'h0);
    repeat (8) @(posedge mclk_in);
    chk(36'({busy_out, twelve}), 36'({1'b1, p}));
    pulse(1'b0, r);
    grab(p, w);
    chk(36'(w), 36'({f ~^ r[17], r[16:0]}));
  endtask
  task automatic int_during(input logic [17:0] r);
    logic [17:0] w;
    rt_in <= 1'b1;
    apb(1'b1, 12'h000, 32'h00000023);
    pulse(1'b0, r);
    pulse(1'b1, 18'h0);
    grab(1'b0, w);
    chk(36'({busy_out, w}), 36'({1'b1, r}));
  endtask
  task automatic ext_read(input logic v, input logic [17:0] r);
    rt_in <= 1'b1;
    apb(1'b1, 12'h000, {26'h0, 1'b1, 1'b0, v, 1'b1, 2'h3});
    host_u.park(v);
    pulse(1'b0, r);
    host_u.read(35, v);
    chk(36'({oe_n, word[35:18]}), 36'({1'b1, r}));
    chk(36'(word[16:0]), 36'h1FFFF);
  endtask
  task automatic late_irq();
    logic seen;
    seen = 1'b0;
    apb(1'b1, 12'h000, 32'h00000027);
    host_u.park(1'b0);
    apb(1'b1, 12'h008, 32'h2);
    pulse(1'b0, 18'h00001);
    host_u.read(5, 1'b0);
    pulse(1'b0, 18'h00002);
    repeat (4) @(posedge mclk_in) seen = seen | late_read_flag_out;
    chk(36'(seen), 36'h1);
    irq_is(1'b1);
    apb(1'b1, 12'h008, 32'h0);
    irq_is(1'b0);
    apb(1'b1, 12'h008, 32'h2);
    irq_is(1'b1);
    apb(1'b1, 12'h004, 32'h2);
    irq_is(1'b0);
    // late bit cleared, result-ready and read-done bits still set
    apb(1'b0, 12'h004, 32'h0);
    chk(36'(q), 36'h5);
    apb(1'b0, 12'h00C, 32'h0);
    chk(36'(q), 36'h2);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    regs_reset();
    par_pins();
    int_read(1'b0, 1'b0, 1'b1, 18'h2A5B4);
    int_read(1'b1, 1'b1, 1'b0, 18'h15A4C);
    int_during(18'h3C0F2);
    ext_read(1'b0, 18'h2A5B4);
    ext_read(1'b1, 18'h0B2E6);
    late_irq();
    results();
  end
endmodule // adc_serial_result_port_tb_top
